// file: logic/stoc_top.sv
// sweep trigger state machine, rear panel control settings and rf output control
// assumes a parser delivers one decoded command per cmd_valid pulse on clk
`timescale 1ns/1ps
module stoc_top
#(
   parameter logic [31:0] SERIAL_NUMBER = 32'h0000_1234 // arbitrary value
)
(
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                cmd_valid,
   input  stoc_pkg::stoc_req_t      cmd,
   input  wire logic                bus_trigger,
   input  wire logic                sweep_done,
   input  wire logic                sweep_retrace,
   input  wire logic                freq_changing,
   input  wire logic                sweep_conflict,
   output logic                     resp_valid,
   output logic [31:0]              resp_data,
   output stoc_pkg::stoc_err_t      err,
   output logic                     armed,
   output logic                     sweeping,
   output logic                     sweep_start,
   output logic                     sweep_abort,
   output logic                     blank_out_pos,
   output logic                     blank_out_neg,
   output logic                     penlift_closed,
   output logic                     horizontal_ramp_output_en,
   output logic                     ramp_rest_top,
   output logic [31:0]              ramp_time_ms,
   output logic [31:0]              sweep_time_ms,
   output logic                     display_on,
   output logic                     rf_on
);
   typedef enum logic [1:0] {STOC_IDLE, STOC_ARMED, STOC_SWEEP} stoc_state_t;
   stoc_state_t state_q;
   logic        cont_q, blank_pol_q, pen_pol_q, rest_q, ramp_en_q, disp_q, rf_en_q;
   logic        fc_q, rt_q, start_q, abort_q, resp_valid_q;
   logic [31:0] ramp_q, resp_q;
   stoc_pkg::stoc_src_t src_q;
   stoc_pkg::stoc_err_t err_q, chk_err;
   logic        chk_ok, is_arm, is_cont_on, is_trig_sweep, is_abort, arm_req, trig_true;
   logic        ramp_wr;
   logic [31:0] ramp_val;

   assign is_arm     = cmd_valid && cmd.code == stoc_pkg::STOC_CMD_ARM;
   assign is_cont_on = cmd_valid && cmd.code == stoc_pkg::STOC_CMD_CONT && cmd.arg[0];
   assign is_trig_sweep = cmd_valid && cmd.code == stoc_pkg::STOC_CMD_TRIG_SWEEP;
   assign is_abort   = cmd_valid && cmd.code == stoc_pkg::STOC_CMD_ABORT;
   // continuous rearm on from idle counts as an arm
   assign arm_req    = (is_arm && !cont_q) || (is_cont_on && !cont_q);
   assign trig_true  = src_q == stoc_pkg::STOC_SRC_IMM ||
                       (src_q == stoc_pkg::STOC_SRC_BUS && bus_trigger);

   stoc_param_check u_check
   (
      .ramp_time_ms   (ramp_q),
      .sweep_conflict (sweep_conflict),
      .ok             (chk_ok),
      .err            (chk_err)
   );

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         state_q <= STOC_IDLE;
      else if (is_abort)
         state_q <= STOC_IDLE;
      else
      begin
         unique case (state_q)
            STOC_IDLE:
               if (((arm_req) || is_trig_sweep) && chk_ok)
                  state_q <= (is_trig_sweep || src_q == stoc_pkg::STOC_SRC_IMM)
                             ? STOC_SWEEP : STOC_ARMED;
            STOC_ARMED:
               if (trig_true)
                  state_q <= STOC_SWEEP;
            STOC_SWEEP:
               if (sweep_done)
                  state_q <= cont_q ? STOC_ARMED : STOC_IDLE;
            default:
               state_q <= STOC_IDLE;
         endcase
      end
   end

   // pulses toward the sweep generator
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         start_q <= 1'b0;
         abort_q <= 1'b0;
      end
      else
      begin
         start_q <= state_q != STOC_SWEEP && !is_abort &&
                    ((state_q == STOC_ARMED && trig_true) ||
                     (state_q == STOC_IDLE && (arm_req || is_trig_sweep) && chk_ok &&
                      (is_trig_sweep || src_q == stoc_pkg::STOC_SRC_IMM)));
         abort_q <= is_abort && state_q == STOC_SWEEP;
      end
   end

   // error reporting, one code per offending command
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         err_q <= '0;
      else
      begin
         err_q <= '0;
         if ((is_arm && (state_q != STOC_IDLE || cont_q)))
         begin
            err_q.valid <= 1'b1;
            err_q.code  <= stoc_pkg::STOC_ERR_INIT;
         end
         else if ((arm_req || is_trig_sweep) && state_q == STOC_IDLE && !chk_ok)
            err_q <= chk_err;
         else if (cmd_valid && cmd.code == stoc_pkg::STOC_CMD_RAMP_TIME &&
                  (cmd.arg < stoc_pkg::STOC_RAMP_MIN_MS ||
                   cmd.arg > stoc_pkg::STOC_RAMP_MAX_MS))
         begin
            err_q.valid <= 1'b1;
            err_q.code  <= stoc_pkg::STOC_ERR_PARAM;
         end
         else if (ramp_wr && state_q == STOC_SWEEP)
         begin
            err_q.valid <= 1'b1;
            err_q.code  <= stoc_pkg::STOC_ERR_SETTING;
         end
      end
   end

   // continuous rearm flag
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         cont_q <= stoc_pkg::STOC_RST_CONT;
      else if (cmd_valid && cmd.code == stoc_pkg::STOC_CMD_CONT)
         cont_q <= cmd.arg[0];
   end

   // plain settings; abort leaves them alone
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         blank_pol_q <= stoc_pkg::STOC_POL_NORMAL;
         pen_pol_q   <= stoc_pkg::STOC_POL_NORMAL;
         rest_q      <= stoc_pkg::STOC_REST_STOP;
         ramp_en_q   <= stoc_pkg::STOC_RST_RAMP_EN;
         disp_q      <= stoc_pkg::STOC_RST_DISP;
         rf_en_q     <= stoc_pkg::STOC_RST_RF_EN;
         fc_q        <= stoc_pkg::STOC_RST_FCBLANK;
         rt_q        <= stoc_pkg::STOC_RST_RTBLANK;
         src_q       <= stoc_pkg::STOC_SRC_IMM;
      end
      else if (cmd_valid)
      begin
         unique case (cmd.code)
            stoc_pkg::STOC_CMD_BLANK_POL: blank_pol_q <= cmd.arg[0];
            stoc_pkg::STOC_CMD_PEN_POL:   pen_pol_q   <= cmd.arg[0];
            stoc_pkg::STOC_CMD_RAMP_REST: rest_q      <= cmd.arg[0];
            stoc_pkg::STOC_CMD_RAMP_EN:   ramp_en_q   <= cmd.arg[0];
            stoc_pkg::STOC_CMD_DISP:      disp_q      <= cmd.arg[0];
            stoc_pkg::STOC_CMD_RF_EN:     rf_en_q     <= cmd.arg[0];
            stoc_pkg::STOC_CMD_FCBLANK:   fc_q        <= cmd.arg[0];
            stoc_pkg::STOC_CMD_RTBLANK:   rt_q        <= cmd.arg[0];
            stoc_pkg::STOC_CMD_TRIG_SRC:  src_q       <= stoc_pkg::stoc_src_t'(cmd.arg[1:0]);
            default:
            begin
            end
         endcase
      end
   end

   // ramp time; one register feeds both ramp and sweep time so they never differ
   always_comb
   begin
      ramp_wr  = 1'b0;
      ramp_val = cmd.arg;
      if (cmd_valid && cmd.code == stoc_pkg::STOC_CMD_RAMP_MIN)
      begin
         ramp_wr  = 1'b1;
         ramp_val = stoc_pkg::STOC_RAMP_MIN_MS;
      end
      else if (cmd_valid && cmd.code == stoc_pkg::STOC_CMD_RAMP_MAX)
      begin
         ramp_wr  = 1'b1;
         ramp_val = stoc_pkg::STOC_RAMP_MAX_MS;
      end
      else if (cmd_valid && cmd.code == stoc_pkg::STOC_CMD_RAMP_TIME)
         ramp_wr  = cmd.arg >= stoc_pkg::STOC_RAMP_MIN_MS &&
                    cmd.arg <= stoc_pkg::STOC_RAMP_MAX_MS;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ramp_q <= stoc_pkg::STOC_RAMP_MIN_MS;
      else if (ramp_wr && state_q != STOC_SWEEP)
         ramp_q <= ramp_val;
   end

   // query answers, one cycle after the command
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         resp_valid_q <= 1'b0;
         resp_q       <= '0;
      end
      else
      begin
         resp_valid_q <= cmd_valid && cmd.code == stoc_pkg::STOC_CMD_QUERY;
         if (cmd_valid && cmd.code == stoc_pkg::STOC_CMD_QUERY)
         begin
            unique case (cmd.query)
               stoc_pkg::STOC_Q_BLANK_POL:  resp_q <= {31'h0, blank_pol_q};
               stoc_pkg::STOC_Q_PEN_POL:    resp_q <= {31'h0, pen_pol_q};
               stoc_pkg::STOC_Q_RAMP_REST:  resp_q <= {31'h0, rest_q};
               stoc_pkg::STOC_Q_RAMP_EN:    resp_q <= {31'h0, ramp_en_q};
               stoc_pkg::STOC_Q_RAMP_TIME,
               stoc_pkg::STOC_Q_SWEEP_TIME: resp_q <= ramp_q;
               stoc_pkg::STOC_Q_DISP:       resp_q <= {31'h0, disp_q};
               stoc_pkg::STOC_Q_RF_EN:      resp_q <= {31'h0, rf_en_q};
               stoc_pkg::STOC_Q_FCBLANK:    resp_q <= {31'h0, fc_q};
               stoc_pkg::STOC_Q_RTBLANK:    resp_q <= {31'h0, rt_q};
               stoc_pkg::STOC_Q_CONT:       resp_q <= {31'h0, cont_q};
               stoc_pkg::STOC_Q_IMPEDANCE:  resp_q <= stoc_pkg::STOC_IMPED_OHMS;
               stoc_pkg::STOC_Q_SERIAL:     resp_q <= SERIAL_NUMBER;
               stoc_pkg::STOC_Q_TRIG_STATE: resp_q <= {30'h0, state_q};
               default:                     resp_q <= '0;
            endcase
         end
      end
   end

   stoc_rf_gate u_rf
   (
      .clk           (clk),
      .rst           (rst),
      .rf_en         (rf_en_q),
      .fc_blank_en   (fc_q),
      .rt_blank_en   (rt_q),
      .freq_changing (freq_changing),
      .retrace       (sweep_retrace),
      .rf_on         (rf_on)
   );

   assign resp_valid    = resp_valid_q;
   assign resp_data     = resp_q;
   assign err           = err_q;
   assign armed         = state_q == STOC_ARMED;
   assign sweeping      = state_q == STOC_SWEEP;
   assign sweep_start   = start_q;
   assign sweep_abort   = abort_q;
   // blanking level only during retrace, sign from polarity
   assign blank_out_pos = sweep_retrace && blank_pol_q == stoc_pkg::STOC_POL_NORMAL;
   assign blank_out_neg = sweep_retrace && blank_pol_q != stoc_pkg::STOC_POL_NORMAL;
   // contact closes for a lift; inverted sense swaps the resting contact
   assign penlift_closed            = pen_pol_q ^ sweep_retrace;
   assign horizontal_ramp_output_en = ramp_en_q;
   assign ramp_rest_top             = rest_q;
   assign ramp_time_ms              = ramp_q;
   assign sweep_time_ms             = ramp_q;
   assign display_on                = disp_q;

   a_arm_from_idle: assert property (@(posedge clk) disable iff (rst)
      is_arm && !cont_q && state_q == STOC_IDLE && chk_ok && !is_abort
      |=> state_q != STOC_IDLE) else $error("arm did not leave idle");
   a_arm_refused: assert property (@(posedge clk) disable iff (rst)
      is_arm && (state_q != STOC_IDLE || cont_q)
      |=> err.valid && err.code == stoc_pkg::STOC_ERR_INIT) else $error("no -213");
   a_check_blocks: assert property (@(posedge clk) disable iff (rst)
      state_q == STOC_IDLE && !chk_ok |=> state_q == STOC_IDLE)
      else $error("armed with bad parameters");
   a_done_rearm: assert property (@(posedge clk) disable iff (rst)
      state_q == STOC_SWEEP && sweep_done && !is_abort
      |=> state_q == ($past(cont_q) ? STOC_ARMED : STOC_IDLE))
      else $error("wrong state after sweep");
   a_abort_idle: assert property (@(posedge clk) disable iff (rst)
      is_abort |=> state_q == STOC_IDLE && $stable(ramp_q)) else $error("abort failed");
   a_ramp_locked: assert property (@(posedge clk) disable iff (rst)
      state_q == STOC_SWEEP && !is_abort |=> $stable(ramp_q))
      else $error("ramp time changed in sweep");
   a_ramp_bounds: assert property (@(posedge clk) disable iff (rst)
      ramp_q >= stoc_pkg::STOC_RAMP_MIN_MS && ramp_q <= stoc_pkg::STOC_RAMP_MAX_MS)
      else $error("ramp time out of range");
   a_impedance_q: assert property (@(posedge clk) disable iff (rst)
      cmd_valid && cmd.code == stoc_pkg::STOC_CMD_QUERY &&
      cmd.query == stoc_pkg::STOC_Q_IMPEDANCE
      |=> resp_valid && resp_data == stoc_pkg::STOC_IMPED_OHMS)
      else $error("impedance wrong");
   a_query_pure: assert property (@(posedge clk) disable iff (rst)
      cmd_valid && cmd.code == stoc_pkg::STOC_CMD_QUERY && state_q != STOC_SWEEP
      && !trig_true |=> $stable(state_q)) else $error("query moved trigger");
   c_imm_arm: cover property (@(posedge clk) disable iff (rst)
      is_arm && state_q == STOC_IDLE ##1 state_q == STOC_SWEEP);
   c_cont_rearm: cover property (@(posedge clk) disable iff (rst)
      cont_q && state_q == STOC_SWEEP && sweep_done ##1 state_q == STOC_ARMED);
   c_abort_sweep: cover property (@(posedge clk) disable iff (rst)
      state_q == STOC_SWEEP && is_abort);
endmodule : stoc_top

// file: shared/stoc_pkg.sv
// package for the sweep trigger and output control block
// assumes a decoded command strobe with code and argument from a parser upstream
// Function
// - arm command moves the trigger machine from idle to armed
// - arm while not idle or continuous rearm on is ignored, error -213 logged
// - arm or triggered sweep checks sweep parameters; failure blocks arming, errors queued
// - continuous rearm returns to armed after each sweep; off after reset
// - enabling continuous rearm arms like an arm command and sets rearm flag
// - immediate trigger source makes arm start a sweep at once if idle of sweeps
// - retrace blank polarity selects positive when normal, negative when inverted; default normal
// - penlift relay normally open when normal, normally closed when inverted; default normal
// - ramp rests at bottom for start, at top for stop; default stop
// - ramp enable switches the horizontal ramp output; default off
// - ramp time accepted from 30 ms to 99 s or min/max; default 30 ms
// - writing ramp time also updates analog sweep time; both always equal
// - ramp time change is refused while a sweep is in progress
// - display enable shows or hides frequency, power, modulation; default shown
// - rf output enable switches rf output; default off
// - frequency change protection blanks rf during frequency changes; default on
// - retrace protection blanks rf during retrace; default off
// - output impedance query returns fixed 50 ohms, not settable
// - diagnostic query returns the instrument serial number
// - sweep completion returns to idle, or to armed with continuous rearm on
// - abort ends sweep, returns to idle at once, other settings untouched
package stoc_pkg;
   typedef enum logic [4:0] {
      STOC_CMD_NOP, STOC_CMD_ARM, STOC_CMD_TRIG_SWEEP, STOC_CMD_ABORT, STOC_CMD_CONT,
      STOC_CMD_BLANK_POL, STOC_CMD_PEN_POL, STOC_CMD_RAMP_REST, STOC_CMD_RAMP_EN,
      STOC_CMD_RAMP_TIME, STOC_CMD_RAMP_MIN, STOC_CMD_RAMP_MAX, STOC_CMD_DISP,
      STOC_CMD_RF_EN, STOC_CMD_FCBLANK, STOC_CMD_RTBLANK, STOC_CMD_TRIG_SRC,
      STOC_CMD_QUERY
   } stoc_cmd_t;
   typedef enum logic [3:0] {
      STOC_Q_BLANK_POL, STOC_Q_PEN_POL, STOC_Q_RAMP_REST, STOC_Q_RAMP_EN,
      STOC_Q_RAMP_TIME, STOC_Q_DISP, STOC_Q_RF_EN, STOC_Q_FCBLANK, STOC_Q_RTBLANK,
      STOC_Q_CONT, STOC_Q_IMPEDANCE, STOC_Q_SERIAL, STOC_Q_TRIG_STATE, STOC_Q_SWEEP_TIME
   } stoc_query_t;
   typedef enum logic [1:0] {STOC_SRC_IMM, STOC_SRC_BUS, STOC_SRC_HOLD} stoc_src_t;
   localparam int          STOC_ARG_W       = 32;
   // ramp time held in milliseconds
   localparam logic [31:0] STOC_RAMP_MIN_MS = 32'h0000_001E;
   localparam logic [31:0] STOC_RAMP_MAX_MS = 32'h0001_82B8;
   localparam logic [31:0] STOC_IMPED_OHMS  = 32'h0000_0032;
   localparam logic [15:0] STOC_ERR_INIT    = 16'hFF2B; // -213
   localparam logic [15:0] STOC_ERR_PARAM   = 16'hFF26; // -218, parameter out of range
   localparam logic [15:0] STOC_ERR_SETTING = 16'hFF23; // -221, settings conflict
   localparam logic        STOC_POL_NORMAL  = 1'b0;
   localparam logic        STOC_REST_STOP   = 1'b1;
   localparam logic        STOC_RST_RAMP_EN = 1'b0;
   localparam logic        STOC_RST_DISP    = 1'b1;
   localparam logic        STOC_RST_RF_EN   = 1'b0;
   localparam logic        STOC_RST_FCBLANK = 1'b1;
   localparam logic        STOC_RST_RTBLANK = 1'b0;
   localparam logic        STOC_RST_CONT    = 1'b0;
   typedef struct packed {
      stoc_cmd_t        code;
      stoc_query_t      query;
      logic [31:0]      arg;
   } stoc_req_t;
   typedef struct packed {
      logic        valid;
      logic [15:0] code;
   } stoc_err_t;
endpackage : stoc_pkg

// file: logic/stoc_param_check.sv
// sweep parameter compatibility and bounds check, combinational
// assumes the sweep sub-blocks report their own conflicts as a level
`timescale 1ns/1ps
module stoc_param_check
(
   input  wire logic [31:0]     ramp_time_ms,
   input  wire logic            sweep_conflict,
   output logic                 ok,
   output stoc_pkg::stoc_err_t  err
);
   always_comb
   begin
      ok       = 1'b1;
      err      = '0;
      if (ramp_time_ms < stoc_pkg::STOC_RAMP_MIN_MS ||
          ramp_time_ms > stoc_pkg::STOC_RAMP_MAX_MS)
      begin
         ok       = 1'b0;
         err.valid = 1'b1;
         err.code  = stoc_pkg::STOC_ERR_PARAM;
      end
      else if (sweep_conflict)
      begin
         ok       = 1'b0;
         err.valid = 1'b1;
         err.code  = stoc_pkg::STOC_ERR_SETTING;
      end
   end
endmodule : stoc_param_check

// file: logic/stoc_rf_gate.sv
// rf on/off gate with frequency change and retrace blanking
// assumes freq_changing and retrace come from logic on the same clock
`timescale 1ns/1ps
module stoc_rf_gate
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic rf_en,
   input  wire logic fc_blank_en,
   input  wire logic rt_blank_en,
   input  wire logic freq_changing,
   input  wire logic retrace,
   output logic      rf_on
);
   logic rf_on_q;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rf_on_q <= 1'b0;
      else
         rf_on_q <= rf_en && !(fc_blank_en && freq_changing)
                    && !(rt_blank_en && retrace);
   end
   assign rf_on = rf_on_q;
   a_rf_blank_fc: assert property (@(posedge clk) disable iff (rst)
      fc_blank_en && freq_changing |=> !rf_on) else $error("rf on during freq change");
   a_rf_blank_rt: assert property (@(posedge clk) disable iff (rst)
      rt_blank_en && retrace |=> !rf_on) else $error("rf on during retrace");
   a_rf_follow: assert property (@(posedge clk) disable iff (rst)
      rf_en && !freq_changing && !retrace |=> rf_on) else $error("rf not on");
endmodule : stoc_rf_gate

// file: testbench/stoc_host_model.sv
// host controller model: issues one decoded command per call
// assumes block outputs settle within 1 ns of the clock edge
`timescale 1ns/1ps
module stoc_host_model
(
   input  wire logic           clk,
   output logic                cmd_valid,
   output stoc_pkg::stoc_req_t cmd,
   input  wire logic           resp_valid,
   input  wire logic [31:0]    resp_data,
   input  stoc_pkg::stoc_err_t err
);
   logic                rsp_v;
   logic [31:0]         rsp_d;
   stoc_pkg::stoc_err_t err_q;
   initial
   begin
      cmd_valid = 1'b0;
      cmd       = '0;
   end
   task automatic send(input stoc_pkg::stoc_cmd_t c, input stoc_pkg::stoc_query_t s,
                       input logic [31:0] a);
      @(posedge clk);
      #1;
      cmd_valid = 1'b1;
      cmd       = '{code: c, query: s, arg: a};
      @(posedge clk);
      #1;
      rsp_v     = resp_valid;
      rsp_d     = resp_data;
      err_q     = err;
      cmd_valid = 1'b0;
      // stale argument would hide a strobe qualification slip
      cmd.arg   = ~a;
   endtask : send
endmodule : stoc_host_model

// file: testbench/tb_stoc_top.sv
// self-checking bench for the sweep trigger and output control block
// assumes the host model owns the command strobe; sweep status comes from here
`timescale 1ns/1ps
module tb_stoc_top;
   localparam logic [31:0] SER = 32'h0000_5A5A; // arbitrary value
   logic                clk = 1'b0;
   logic                rst = 1'b1;
   logic                cmd_valid, bus_trigger = 1'b0, sweep_done = 1'b0;
   logic                sweep_retrace = 1'b0, freq_changing = 1'b0, sweep_conflict = 1'b0;
   stoc_pkg::stoc_req_t cmd;
   stoc_pkg::stoc_err_t err;
   logic                resp_valid, armed, sweeping, sweep_start, blank_out_pos, blank_out_neg;
   logic                penlift_closed, ramp_en, ramp_rest_top, display_on, rf_on, sweep_abort;
   logic [31:0]         resp_data, ramp_time_ms, sweep_time_ms;
   int                  error_cnt = 0;
   int                  checks = 0;
   always #2.5 clk = ~clk;
   stoc_host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd),
      .resp_valid(resp_valid), .resp_data(resp_data), .err(err));
   stoc_top #(.SERIAL_NUMBER(SER)) dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
      .cmd(cmd), .bus_trigger(bus_trigger), .sweep_done(sweep_done),
      .sweep_retrace(sweep_retrace), .freq_changing(freq_changing),
      .sweep_conflict(sweep_conflict), .resp_valid(resp_valid), .resp_data(resp_data),
      .err(err), .armed(armed), .sweeping(sweeping), .sweep_start(sweep_start),
      .sweep_abort(sweep_abort), .blank_out_pos(blank_out_pos), .blank_out_neg(blank_out_neg),
      .penlift_closed(penlift_closed), .horizontal_ramp_output_en(ramp_en),
      .ramp_rest_top(ramp_rest_top), .ramp_time_ms(ramp_time_ms),
      .sweep_time_ms(sweep_time_ms), .display_on(display_on), .rf_on(rf_on));
   task automatic chk_b(input logic got, input logic exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected flag at %0t: got %b expected %b", $time, got, exp);
      end
   endtask : chk_b
   task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_w
   task automatic go(input stoc_pkg::stoc_cmd_t c, input logic [31:0] a);
      host.send(c, stoc_pkg::STOC_Q_BLANK_POL, a);
   endtask : go
   task automatic q(input stoc_pkg::stoc_query_t s, input logic [31:0] exp);
      host.send(stoc_pkg::STOC_CMD_QUERY, s, 32'h0);
      chk_b(host.rsp_v, 1'b1);
      chk_w(host.rsp_d, exp);
   endtask : q
   task automatic e(input logic [15:0] code);
      chk_b(host.err_q.valid, 1'b1);
      chk_w({16'h0, host.err_q.code}, {16'h0, code});
   endtask : e
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic t_defaults;
      chk_w(ramp_time_ms, 32'h0000_001E);
      chk_w(sweep_time_ms, 32'h0000_001E);
      chk_b(ramp_rest_top, 1'b1);
      chk_b(ramp_en, 1'b0);
      chk_b(display_on, 1'b1);
      chk_b(rf_on, 1'b0);
      q(stoc_pkg::STOC_Q_FCBLANK, 32'h1);
      q(stoc_pkg::STOC_Q_RTBLANK, 32'h0);
      q(stoc_pkg::STOC_Q_CONT, 32'h0);
      q(stoc_pkg::STOC_Q_IMPEDANCE, 32'h0000_0032);
      q(stoc_pkg::STOC_Q_SERIAL, SER);
   endtask : t_defaults
   task automatic t_arm;
      go(stoc_pkg::STOC_CMD_TRIG_SRC, 32'h1);
      go(stoc_pkg::STOC_CMD_ARM, 32'h0);
      chk_b(armed, 1'b1);
      go(stoc_pkg::STOC_CMD_ARM, 32'h0);
      e(16'hFF2B);
      go(stoc_pkg::STOC_CMD_ABORT, 32'h0);
      chk_b(armed, 1'b0);
      // hold source never fires, even with a bus trigger present
      go(stoc_pkg::STOC_CMD_TRIG_SRC, 32'h2);
      go(stoc_pkg::STOC_CMD_ARM, 32'h0);
      bus_trigger = 1'b1;
      tick(2);
      bus_trigger = 1'b0;
      chk_b(armed, 1'b1);
      go(stoc_pkg::STOC_CMD_ABORT, 32'h0);
      chk_b(armed, 1'b0);
   endtask : t_arm
   task automatic t_imm;
      go(stoc_pkg::STOC_CMD_TRIG_SRC, 32'h0);
      go(stoc_pkg::STOC_CMD_ARM, 32'h0);
      chk_b(sweep_start, 1'b1);
      chk_b(sweeping, 1'b1);
      go(stoc_pkg::STOC_CMD_RAMP_TIME, 32'h0000_0064);
      e(16'hFF23);
      chk_w(ramp_time_ms, 32'h0000_001E);
      sweep_done = 1'b1;
      tick(1);
      sweep_done = 1'b0;
      chk_b(sweeping, 1'b0);
      chk_b(armed, 1'b0);
      go(stoc_pkg::STOC_CMD_ARM, 32'h0);
      chk_b(sweeping, 1'b1);
      go(stoc_pkg::STOC_CMD_ABORT, 32'h0);
      chk_b(sweep_abort, 1'b1);
      chk_b(sweeping, 1'b0);
   endtask : t_imm
   task automatic t_cont;
      go(stoc_pkg::STOC_CMD_TRIG_SRC, 32'h1);
      go(stoc_pkg::STOC_CMD_CONT, 32'h1);
      chk_b(armed, 1'b1);
      go(stoc_pkg::STOC_CMD_ARM, 32'h0);
      e(16'hFF2B);
      bus_trigger = 1'b1;
      tick(1);
      bus_trigger = 1'b0;
      chk_b(sweep_start, 1'b1);
      for (int i = 0; i < 8 && sweeping !== 1'b1; i++)
         tick(1);
      chk_b(sweeping, 1'b1);
      sweep_done = 1'b1;
      tick(1);
      sweep_done = 1'b0;
      chk_b(armed, 1'b1);
      go(stoc_pkg::STOC_CMD_ABORT, 32'h0);
      chk_b(armed, 1'b0);
      q(stoc_pkg::STOC_Q_CONT, 32'h1);
      go(stoc_pkg::STOC_CMD_CONT, 32'h0);
   endtask : t_cont
   task automatic t_params;
      sweep_conflict = 1'b1;
      go(stoc_pkg::STOC_CMD_ARM, 32'h0);
      e(16'hFF23);
      go(stoc_pkg::STOC_CMD_TRIG_SWEEP, 32'h0);
      e(16'hFF23);
      chk_b(armed, 1'b0);
      sweep_conflict = 1'b0;
      go(stoc_pkg::STOC_CMD_RAMP_TIME, 32'h0000_001D);
      e(16'hFF26);
      go(stoc_pkg::STOC_CMD_RAMP_TIME, 32'h0001_82B9);
      e(16'hFF26);
      go(stoc_pkg::STOC_CMD_RAMP_MAX, 32'h0);
      chk_w(sweep_time_ms, 32'h0001_82B8);
      q(stoc_pkg::STOC_Q_RAMP_TIME, 32'h0001_82B8);
      q(stoc_pkg::STOC_Q_SWEEP_TIME, 32'h0001_82B8);
      go(stoc_pkg::STOC_CMD_RAMP_MIN, 32'h0);
      chk_w(ramp_time_ms, 32'h0000_001E);
   endtask : t_params
   task automatic t_settings;
      sweep_retrace = 1'b1;
      tick(0);
      chk_b(blank_out_pos, 1'b1);
      go(stoc_pkg::STOC_CMD_BLANK_POL, 32'h1);
      chk_b(blank_out_neg, 1'b1);
      chk_b(blank_out_pos, 1'b0);
      go(stoc_pkg::STOC_CMD_PEN_POL, 32'h1);
      sweep_retrace = 1'b0;
      tick(0);
      chk_b(penlift_closed, 1'b1);
      go(stoc_pkg::STOC_CMD_RAMP_REST, 32'h0);
      chk_b(ramp_rest_top, 1'b0);
      go(stoc_pkg::STOC_CMD_RAMP_EN, 32'h1);
      chk_b(ramp_en, 1'b1);
      go(stoc_pkg::STOC_CMD_DISP, 32'h0);
      chk_b(display_on, 1'b0);
      q(stoc_pkg::STOC_Q_BLANK_POL, 32'h1);
      q(stoc_pkg::STOC_Q_PEN_POL, 32'h1);
      q(stoc_pkg::STOC_Q_DISP, 32'h0);
   endtask : t_settings
   task automatic t_rf;
      go(stoc_pkg::STOC_CMD_RF_EN, 32'h1);
      tick(2);
      chk_b(rf_on, 1'b1);
      freq_changing = 1'b1;
      tick(2);
      chk_b(rf_on, 1'b0);
      go(stoc_pkg::STOC_CMD_FCBLANK, 32'h0);
      tick(2);
      chk_b(rf_on, 1'b1);
      freq_changing = 1'b0;
      sweep_retrace = 1'b1;
      go(stoc_pkg::STOC_CMD_RTBLANK, 32'h1);
      tick(2);
      chk_b(rf_on, 1'b0);
   endtask : t_rf
   task automatic close_out;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : close_out
   initial
   begin
      #50000;
      error_cnt++;
      close_out();
   end
   initial
   begin
      repeat (6) @(posedge clk);
      #1;
      rst = 1'b0;
      t_defaults();
      t_arm();
      t_imm();
      t_cont();
      t_params();
      t_settings();
      t_rf();
      close_out();
   end
endmodule : tb_stoc_top
